// >>> octrc_pkg.sv
// constants, register map and state codes for the oscillator trim / reset cause block
`default_nettype none
package octrc_pkg;
  // register byte offsets
  localparam logic [7:0] OCTRC_TRIM_OFF = 8'h00;
  localparam logic [7:0] OCTRC_CFG_OFF = 8'h04;
  localparam logic [7:0] OCTRC_STAT_OFF = 8'h08;
  localparam logic [7:0] OCTRC_USER_OFF = 8'h0c;
  localparam logic [7:0] OCTRC_KEEP_OFF = 8'h10;
  // trim register fields
  localparam int OCTRC_FINE_LSB = 4;
  localparam int OCTRC_FAST_BIT = 3;
  localparam int OCTRC_SLOW_BIT = 2;
  localparam logic [7:0] OCTRC_TRIM_RST = 8'h70;
  localparam logic [7:0] OCTRC_TRIM_MASK = 8'hfc;
  // status register fields
  localparam int OCTRC_PD_BIT = 0;
  localparam int OCTRC_TO_BIT = 1;
  localparam int OCTRC_POR_BIT = 2;
  localparam int OCTRC_SLEEP_BIT = 3;
  localparam int OCTRC_KIND_LSB = 4;
  // reset values
  localparam logic [2:0] OCTRC_CFG_RST = 3'h5;
  localparam logic [7:0] OCTRC_USER_RST = 8'h00;
  // oscillator selection codes
  localparam logic [2:0] OCTRC_EXT_RC_CLK = 3'h7;
  localparam logic [2:0] OCTRC_EXT_RC_IO = 3'h6;
  localparam logic [2:0] OCTRC_INT_RC_CLK = 3'h5;
  localparam logic [2:0] OCTRC_INT_RC_IO = 3'h4;
  localparam logic [2:0] OCTRC_INVALID = 3'h3;
  localparam logic [2:0] OCTRC_HS_XTAL = 3'h2;
  localparam logic [2:0] OCTRC_MED_XTAL = 3'h1;
  localparam logic [2:0] OCTRC_LP_XTAL = 3'h0;
  // reset kinds
  localparam logic [1:0] OCTRC_KIND_POR = 2'h0;
  localparam logic [1:0] OCTRC_KIND_MASTER_CLEAR_PIN = 2'h1;
  localparam logic [1:0] OCTRC_KIND_MASTER_CLEAR_PIN_SLP = 2'h2;
  localparam logic [1:0] OCTRC_KIND_WDT = 2'h3;
  // timing
  localparam int OCTRC_CLK_KHZ = 50000;
  localparam int OCTRC_CLK_NS = 20;
  localparam int OCTRC_RC_NOM_KHZ = 4000;
  localparam int OCTRC_RC_NOM_STEP = (OCTRC_RC_NOM_KHZ * 65536) / OCTRC_CLK_KHZ;
  localparam int OCTRC_FINE_STEP = 16;
  localparam int OCTRC_COARSE_STEP = 256;
  localparam int OCTRC_STEP_LOW = OCTRC_RC_NOM_STEP - 8 * OCTRC_FINE_STEP;
  localparam int OCTRC_MASTER_CLEAR_PIN_FILT_NS = 200;
  localparam int OCTRC_MASTER_CLEAR_PIN_FILT_CYC = (OCTRC_MASTER_CLEAR_PIN_FILT_NS + OCTRC_CLK_NS - 1) / OCTRC_CLK_NS;
  // sleep state machine
  typedef enum logic [1:0] {
    OCTRC_ST_RUN = 2'b01,
    OCTRC_ST_SLEEP = 2'b10
  } octrc_state_t;
endpackage
`default_nettype wire

// >>> octrc_core.sv
// oscillator trim, divided clock output and reset cause logic behind an APB slave
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module octrc_core (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] PADDR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic MASTER_CLEAR_PIN_N,
  input wire logic WDT_TIMEOUT,
  input wire logic WAKE_IRQ,
  input wire logic OSC_IN_I,
  output logic OSC_IN_O,
  output logic OSC_IN_OE,
  output logic OSC_OUT_O,
  output logic OSC_OUT_OE,
  output logic OSC_TICK,
  output logic DEVICE_RESET,
  output logic [1:0] RESET_KIND
);
  import octrc_pkg::*;

  octrc_state_t state;
  octrc_state_t next_state;
  logic [7:0] trim;
  logic [2:0] osc_sel;
  logic [7:0] user_reg;
  logic [7:0] keep_reg;
  logic timeout_flag;
  logic powerdown_flag;
  logic power_on_flag;
  logic [3:0] filt_cnt;
  logic master_clear_pin_act;
  logic [15:0] rc_acc;
  logic osc_in_q;
  logic [1:0] div_cnt;

  // apb decode
  wire apb_acc = PSEL & PENABLE & PREADY;
  wire apb_wr = apb_acc & PWRITE;
  wire hit_trim = (PADDR == OCTRC_TRIM_OFF);
  wire hit_cfg = (PADDR == OCTRC_CFG_OFF);
  wire hit_stat = (PADDR == OCTRC_STAT_OFF);
  wire hit_user = (PADDR == OCTRC_USER_OFF);
  wire hit_keep = (PADDR == OCTRC_KEEP_OFF);
  wire hit_any = hit_trim | hit_cfg | hit_stat | hit_user | hit_keep;
  wire wr_trim = apb_wr & hit_trim;
  wire wr_cfg = apb_wr & hit_cfg;
  wire wr_stat = apb_wr & hit_stat;
  wire wr_user = apb_wr & hit_user;
  wire wr_keep = apb_wr & hit_keep;

  // reset event decode
  wire sleeping = (state == OCTRC_ST_SLEEP);
  wire master_clear_pin_rise = (filt_cnt == 4'(OCTRC_MASTER_CLEAR_PIN_FILT_CYC - 1)) & ~MASTER_CLEAR_PIN_N & ~master_clear_pin_act;
  wire wdt_reset = WDT_TIMEOUT & ~sleeping & ~master_clear_pin_act;
  wire wdt_wake = WDT_TIMEOUT & sleeping & ~master_clear_pin_act;
  wire irq_wake = WAKE_IRQ & sleeping & ~master_clear_pin_act & ~WDT_TIMEOUT;
  wire dev_rst = master_clear_pin_act | wdt_reset;
  wire sleep_req = wr_stat & PWDATA[OCTRC_SLEEP_BIT] & ~dev_rst & ~sleeping & ~master_clear_pin_rise;

  // oscillator mode decode
  // selection 011 matches no mode, so no oscillator edge is ever produced
  wire mode_ext_rc = (osc_sel == OCTRC_EXT_RC_CLK) | (osc_sel == OCTRC_EXT_RC_IO);
  wire mode_int_rc = (osc_sel == OCTRC_INT_RC_CLK) | (osc_sel == OCTRC_INT_RC_IO);
  wire mode_xtal = (osc_sel == OCTRC_HS_XTAL) | (osc_sel == OCTRC_MED_XTAL)
      | (osc_sel == OCTRC_LP_XTAL);
  wire divided_clock_out_mode = (osc_sel == OCTRC_INT_RC_CLK) | (osc_sel == OCTRC_EXT_RC_CLK);

  // internal rc rate step from the trim fields
  wire [3:0] trim_fine = trim[7:OCTRC_FINE_LSB];
  wire [16:0] fine_add = 17'(trim_fine) * 17'(OCTRC_FINE_STEP);
  wire [16:0] fast_add = trim[OCTRC_FAST_BIT] ? 17'(OCTRC_COARSE_STEP) : 17'h0;
  wire [16:0] slow_sub = trim[OCTRC_SLOW_BIT] ? 17'(OCTRC_COARSE_STEP) : 17'h0;
  wire [16:0] rc_step = 17'(OCTRC_STEP_LOW) + fine_add + fast_add - slow_sub;
  wire [16:0] rc_sum = {1'b0, rc_acc} + rc_step;

  // selected oscillator edge: internal accumulator or the first pin
  wire pin_edge = OSC_IN_I & ~osc_in_q;
  wire osc_edge = mode_int_rc ? rc_sum[16] : ((mode_xtal | mode_ext_rc) & pin_edge);

  // sleep state machine
  always_comb begin
    next_state = state;
    case (state)
      OCTRC_ST_RUN: begin
        if (sleep_req) begin
          next_state = OCTRC_ST_SLEEP;
        end
      end
      OCTRC_ST_SLEEP: begin
        if (dev_rst | wdt_wake | irq_wake) begin
          next_state = OCTRC_ST_RUN;
        end
      end
      default: next_state = OCTRC_ST_RUN;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state <= OCTRC_ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // master clear filter: low must persist before it counts as reset
  // any high sample restarts the count, so a glitch never reaches the reset path
  always_ff @(posedge CLK) begin
    if (RESET) begin
      filt_cnt <= 4'h0;
      master_clear_pin_act <= 1'b0;
    end else if (MASTER_CLEAR_PIN_N) begin
      filt_cnt <= 4'h0;
      master_clear_pin_act <= 1'b0;
    end else begin
      if (filt_cnt != 4'(OCTRC_MASTER_CLEAR_PIN_FILT_CYC - 1)) begin
        filt_cnt <= filt_cnt + 4'h1;
      end
      if (master_clear_pin_rise) begin
        master_clear_pin_act <= 1'b1;
      end
    end
  end

  // reset kind, timeout and powerdown flags
  // a clear landing together with a watchdog event wins as the stronger cause
  always_ff @(posedge CLK) begin
    if (RESET) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
      RESET_KIND <= OCTRC_KIND_POR;
    end else if (master_clear_pin_rise & sleeping) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b0;
      RESET_KIND <= OCTRC_KIND_MASTER_CLEAR_PIN_SLP;
    end else if (master_clear_pin_rise) begin
      RESET_KIND <= OCTRC_KIND_MASTER_CLEAR_PIN;
    end else if (wdt_reset) begin
      timeout_flag <= 1'b0;
      RESET_KIND <= OCTRC_KIND_WDT;
    end else if (wdt_wake) begin
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end else if (sleep_req) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end
  end

  // power-on flag: only power-on clears it, software sets it
  always_ff @(posedge CLK) begin
    if (RESET) begin
      power_on_flag <= 1'b0;
    end else if (wr_stat & PWDATA[OCTRC_POR_BIT]) begin
      power_on_flag <= 1'b1;
    end
  end

  // trim and selection survive every reset but power-on
  always_ff @(posedge CLK) begin
    if (RESET) begin
      trim <= OCTRC_TRIM_RST;
      osc_sel <= OCTRC_CFG_RST;
    end else begin
      if (wr_trim) begin
        trim <= PWDATA[7:0] & OCTRC_TRIM_MASK;
      end
      if (wr_cfg) begin
        osc_sel <= PWDATA[2:0];
      end
    end
  end

  // ordinary register: reset on any device reset, not on wake-up
  always_ff @(posedge CLK) begin
    if (RESET | dev_rst) begin
      user_reg <= OCTRC_USER_RST;
    end else if (wr_user) begin
      user_reg <= PWDATA[7:0];
    end
  end

  // retained register: no reset at all
  always_ff @(posedge CLK) begin
    if (wr_keep) begin
      keep_reg <= PWDATA[7:0];
    end
  end

  // internal rc phase accumulator and pin edge history
  // the accumulator carry is the internal oscillator edge; trim only moves the step
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rc_acc <= 16'h0;
      osc_in_q <= 1'b0;
      OSC_TICK <= 1'b0;
    end else begin
      rc_acc <= rc_sum[15:0];
      osc_in_q <= OSC_IN_I;
      OSC_TICK <= osc_edge;
    end
  end

  // divide-by-four counter on the selected oscillator
  always_ff @(posedge CLK) begin
    if (RESET | dev_rst) begin
      div_cnt <= 2'h0;
    end else if (osc_edge) begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // pin drivers: first pin never driven, second carries divided clock
  // the first pin is an input in every mode, so its enable never rises
  always_ff @(posedge CLK) begin
    if (RESET) begin
      OSC_IN_O <= 1'b0;
      OSC_IN_OE <= 1'b0;
      OSC_OUT_O <= 1'b0;
      OSC_OUT_OE <= 1'b0;
      DEVICE_RESET <= 1'b1;
    end else begin
      OSC_IN_O <= 1'b0;
      OSC_IN_OE <= 1'b0;
      OSC_OUT_OE <= divided_clock_out_mode;
      OSC_OUT_O <= divided_clock_out_mode & ~dev_rst & div_cnt[1];
      DEVICE_RESET <= dev_rst;
    end
  end

  // read mux
  // the retained register reads unknown until software writes it after power-on
  wire [7:0] stat_rd = {2'h0, RESET_KIND, sleeping, power_on_flag, timeout_flag, powerdown_flag};
  wire [7:0] rd_byte = hit_trim ? trim
      : hit_cfg ? {5'h0, osc_sel}
      : hit_stat ? stat_rd
      : hit_user ? user_reg
      : hit_keep ? keep_reg : 8'h0;

  // apb answer: one wait state, error on unmapped offsets
  // the wait state gives the read mux a full cycle from registered state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & PENABLE & ~PREADY;
      PRDATA <= (PSEL & PENABLE & ~PREADY & ~PWRITE) ? {24'h0, rd_byte} : 32'h0;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit_any;
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_low_held;
    !MASTER_CLEAR_PIN_N [*8];
  endsequence

  a_trim_low_zero: assert property (trim[1:0] == 2'h0)
    else $error("trim low bits not zero");
  a_fine_faster: assert property (
    (mode_int_rc && trim[3:2] == 2'h0 && trim_fine == 4'hf) |-> rc_step > 17'(OCTRC_RC_NOM_STEP))
    else $error("max fine trim not faster");
  a_coarse_order: assert property (
    trim[OCTRC_FAST_BIT] && !trim[OCTRC_SLOW_BIT]
    |-> rc_step >= 17'(OCTRC_STEP_LOW + OCTRC_COARSE_STEP))
    else $error("coarse up not applied");
  a_divided_clock_out_gate: assert property (!$past(divided_clock_out_mode) |-> !OSC_OUT_OE && !OSC_OUT_O)
    else $error("clock out outside clock out mode");
  a_div_period: assert property (
    osc_edge && !dev_rst && div_cnt == 2'h1 && !$past(dev_rst) |=> div_cnt == 2'h2)
    else $error("divider step wrong");
  a_filt_short: assert property (MASTER_CLEAR_PIN_N ##1 (!MASTER_CLEAR_PIN_N [*3]) ##1 MASTER_CLEAR_PIN_N |-> !master_clear_pin_act)
    else $error("short clear pulse accepted");
  a_filt_long: assert property (MASTER_CLEAR_PIN_N ##1 s_low_held ##1 !MASTER_CLEAR_PIN_N [*2] |=> master_clear_pin_act)
    else $error("long clear not accepted");
  a_wdt_kind: assert property (
    wdt_reset && !master_clear_pin_rise |=> RESET_KIND == OCTRC_KIND_WDT && !timeout_flag)
    else $error("watchdog reset flags wrong");
  a_slp_clear: assert property (
    master_clear_pin_rise && sleeping
    |=> timeout_flag && !powerdown_flag && RESET_KIND == OCTRC_KIND_MASTER_CLEAR_PIN_SLP)
    else $error("sleep clear flags wrong");
  a_por_hold: assert property (power_on_flag && !RESET |=> power_on_flag)
    else $error("power-on flag lost");
  a_pin_float: assert property (##1 !OSC_IN_OE)
    else $error("first oscillator pin driven");
  a_clear_low: assert property (master_clear_pin_act && divided_clock_out_mode |=> !OSC_OUT_O)
    else $error("second pin not low under clear");
  a_wake_keep: assert property (wdt_wake && !wr_user |=> user_reg == $past(user_reg))
    else $error("wake-up disturbed register");

  // reset cause, oscillator selection and retention checks
  a_clear_kind: assert property (
    master_clear_pin_rise && !sleeping |=> RESET_KIND == OCTRC_KIND_MASTER_CLEAR_PIN
    && timeout_flag == $past(timeout_flag) && powerdown_flag == $past(powerdown_flag))
    else $error("run clear flags wrong");
  a_wdt_inside: assert property (wdt_reset |=> DEVICE_RESET)
    else $error("watchdog reset not raised inside");
  a_wake_flags: assert property (
    wdt_wake && !master_clear_pin_rise |=> !timeout_flag && !powerdown_flag)
    else $error("watchdog wake flags wrong");
  a_xtal_tick: assert property (mode_xtal && pin_edge |=> OSC_TICK)
    else $error("external clock edge not taken");
  a_invalid_idle: assert property (osc_sel == OCTRC_INVALID |=> !OSC_TICK)
    else $error("invalid selection ticked");
  a_user_clear: assert property (dev_rst |=> user_reg == OCTRC_USER_RST)
    else $error("register not reset by device reset");
  a_trim_keep: assert property (dev_rst && !wr_trim |=> trim == $past(trim))
    else $error("trim lost on device reset");
endmodule
`default_nettype wire

// >>> octrc_ext_osc.sv
// behavioural external clock source for the first oscillator pin
`timescale 1ns/1ps
`default_nettype none
module octrc_ext_osc #(
  parameter int HALF_NS = 100 // whole clock periods, so edges land on falling clock edges
) (
  input wire logic en,
  output logic osc
);
  // toggles only while enabled, stands still low otherwise
  initial begin
    osc = 1'b0;
  end
  always begin
    #HALF_NS;
    if (en) begin
      osc = ~osc;
    end else begin
      osc = 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> octrc_core_test.sv
// self-checking testbench for the oscillator trim and reset cause block
`timescale 1ns/1ps
`default_nettype none
module octrc_core_test;
  import octrc_pkg::*;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic MASTER_CLEAR_PIN_N = 1'b1;
  logic WDT_TIMEOUT = 1'b0;
  logic WAKE_IRQ = 1'b0;
  logic osc_en = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, OSC_IN_I, OSC_IN_O, OSC_IN_OE, OSC_OUT_O, OSC_OUT_OE;
  logic OSC_TICK, DEVICE_RESET, po, pi;
  logic [1:0] RESET_KIND;
  logic [33:0] q[$];
  logic [33:0] mq;
  logic [31:0] rv;
  int num_errors = 0;
  int checked = 0;
  int tk, ro, ri, nr, k, base;
  int cnt[4];
  logic [7:0] trims[4] = '{8'h00, 8'hf0, 8'h78, 8'h74};

  always #10 CLK = ~CLK;

  octrc_ext_osc u_octrc_ext_osc (.en(osc_en), .osc(OSC_IN_I));

  octrc_core u_octrc_core (.CLK(CLK), .RESET(RESET), .PADDR(PADDR), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MASTER_CLEAR_PIN_N(MASTER_CLEAR_PIN_N), .WDT_TIMEOUT(WDT_TIMEOUT), .WAKE_IRQ(WAKE_IRQ),
    .OSC_IN_I(OSC_IN_I), .OSC_IN_O(OSC_IN_O), .OSC_IN_OE(OSC_IN_OE), .OSC_OUT_O(OSC_OUT_O),
    .OSC_OUT_OE(OSC_OUT_OE), .OSC_TICK(OSC_TICK), .DEVICE_RESET(DEVICE_RESET),
    .RESET_KIND(RESET_KIND));

  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // final counts and verdict
  task stop_test;
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask

  // one apb transfer, expectation noted for the monitor
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
           input logic er);
    int n;
    n = 0;
    q.push_back({w, er, e});
    PSEL <= 1'b1;
    PADDR <= a;
    PWRITE <= w;
    PWDATA <= d;
    PENABLE <= 1'b0;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    if (PREADY !== 1'b1) begin
      num_errors++;
      stop_test;
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, e, 1'b0);
  endtask

  // counts ticks, divided clock rises, pin rises and reset cycles
  task meas(input int n);
    tk = 0;
    ro = 0;
    ri = 0;
    nr = 0;
    repeat (n) begin
      @(posedge CLK);
      if (OSC_TICK === 1'b1) tk++;
      if (OSC_OUT_O === 1'b1 && po === 1'b0) ro++;
      if (OSC_IN_I === 1'b1 && pi === 1'b0) ri++;
      if (DEVICE_RESET === 1'b1) nr++;
      po = OSC_OUT_O;
      pi = OSC_IN_I;
    end
  endtask

  // one-cycle watchdog or wake pulse, then watch device reset
  task kick(input logic w);
    if (w) WDT_TIMEOUT <= 1'b1;
    else WAKE_IRQ <= 1'b1;
    @(posedge CLK);
    WDT_TIMEOUT <= 1'b0;
    WAKE_IRQ <= 1'b0;
    k = (DEVICE_RESET === 1'b1) ? 1 : 0;
    meas(5);
    nr += k;
  endtask

  task hold_clear;
    MASTER_CLEAR_PIN_N <= 1'b0;
    cyc(13);
  endtask

  // read and error monitor
  always @(posedge CLK) begin
    if (PREADY === 1'b1) begin
      if (q.size() == 0) chk(32'h1, 32'h0);
      else begin
        mq = q.pop_front();
        chk(32'(PSLVERR), 32'(mq[32]));
        if (mq[33] == 1'b0) chk(PRDATA, mq[31:0]);
      end
    end
  end

  // main sequence
  initial begin
    void'($urandom(76));
    cyc(3);
    RESET <= 1'b0;
    cyc(1);
    rd(OCTRC_TRIM_OFF, 32'h70);
    rd(OCTRC_CFG_OFF, 32'h5);
    rd(OCTRC_STAT_OFF, 32'h3);
    rd(OCTRC_USER_OFF, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
    wr(OCTRC_TRIM_OFF, 32'hff);
    rd(OCTRC_TRIM_OFF, 32'hfc);
    $display("test reset and map done");
    wr(OCTRC_TRIM_OFF, 32'h70);
    meas(2000);
    chk(32'(tk >= 150 && tk <= 170), 32'h1);
    chk(32'(ro * 4 >= tk - 4 && ro * 4 <= tk + 4), 32'h1);
    base = tk;
    rd(OCTRC_TRIM_OFF, 32'h70);
    for (int i = 0; i < 4; i++) begin
      wr(OCTRC_TRIM_OFF, 32'(trims[i]));
      meas(2000);
      cnt[i] = tk;
    end
    chk(32'(cnt[1] > cnt[0]), 32'h1);
    chk(32'(cnt[2] > base), 32'h1);
    chk(32'(cnt[3] < base), 32'h1);
    $display("test trim done");
    osc_en <= 1'b1;
    wr(OCTRC_CFG_OFF, 32'(OCTRC_HS_XTAL));
    meas(2000);
    chk(32'(tk >= ri - 1 && tk <= ri + 1 && ri > 100), 32'h1);
    wr(OCTRC_CFG_OFF, 32'(OCTRC_INVALID));
    meas(500);
    chk(32'(tk), 32'h0);
    wr(OCTRC_CFG_OFF, 32'(OCTRC_EXT_RC_CLK));
    meas(2000);
    chk(32'(ro * 4 >= tk - 4 && ro * 4 <= tk + 4 && tk > 100), 32'h1);
    osc_en <= 1'b0;
    for (int m = 0; m < 8; m++) begin
      wr(OCTRC_CFG_OFF, 32'(m));
      cyc(1);
      chk(32'(OSC_OUT_OE), 32'(m == 5 || m == 7));
    end
    $display("test clock modes done");
    rv = $urandom & 32'hff;
    wr(OCTRC_KEEP_OFF, rv);
    wr(OCTRC_USER_OFF, rv);
    wr(OCTRC_STAT_OFF, 32'h4);
    MASTER_CLEAR_PIN_N <= 1'b0;
    meas(9);
    MASTER_CLEAR_PIN_N <= 1'b1;
    k = nr;
    meas(6);
    chk(32'(nr + k), 32'h0);
    for (int m = 4; m < 8; m++) begin
      wr(OCTRC_CFG_OFF, 32'(m));
      hold_clear;
      chk(32'(DEVICE_RESET), 32'h1);
      chk(32'(OSC_IN_OE), 32'h0);
      chk(32'(OSC_IN_O), 32'h0);
      chk(32'(OSC_OUT_O), 32'h0);
      chk(32'(OSC_OUT_OE), 32'(m % 2));
      MASTER_CLEAR_PIN_N <= 1'b1;
      cyc(3);
    end
    rd(OCTRC_USER_OFF, 32'h0);
    rd(OCTRC_KEEP_OFF, rv);
    rd(OCTRC_STAT_OFF, 32'h17);
    rd(OCTRC_CFG_OFF, 32'h7);
    $display("test master clear done");
    wr(OCTRC_USER_OFF, rv);
    kick(1'b1);
    chk(32'(nr), 32'h1);
    chk(32'(RESET_KIND), 32'(OCTRC_KIND_WDT));
    rd(OCTRC_STAT_OFF, 32'h35);
    rd(OCTRC_USER_OFF, 32'h0);
    wr(OCTRC_USER_OFF, rv);
    wr(OCTRC_STAT_OFF, 32'h8);
    kick(1'b1);
    chk(32'(nr), 32'h0);
    rd(OCTRC_STAT_OFF, 32'h34);
    rd(OCTRC_USER_OFF, rv);
    wr(OCTRC_STAT_OFF, 32'h8);
    kick(1'b0);
    rd(OCTRC_STAT_OFF, 32'h36);
    wr(OCTRC_STAT_OFF, 32'h8);
    hold_clear;
    MASTER_CLEAR_PIN_N <= 1'b1;
    cyc(3);
    rd(OCTRC_STAT_OFF, 32'h26);
    rd(OCTRC_USER_OFF, 32'h0);
    $display("test watchdog and sleep done");
    RESET <= 1'b1;
    cyc(3);
    RESET <= 1'b0;
    cyc(1);
    chk(32'(RESET_KIND), 32'(OCTRC_KIND_POR));
    rd(OCTRC_STAT_OFF, 32'h3);
    rd(OCTRC_TRIM_OFF, 32'h70);
    rd(OCTRC_CFG_OFF, 32'h5);
    $display("test second reset done");
    stop_test;
  end
endmodule
`default_nettype wire
